// ===== sim/mar_ingress_model.sv
`timescale 1ns/1ps
`default_nettype none
module mar_ingress_model
(
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [72:0] i_frame,
  input wire logic i_ready,
  output logic o_valid,
  output logic [72:0] o_frame
);
  logic valid_q = 1'b0;
  logic [72:0] frame_q = '0;
  always_ff @(posedge i_clock)
  begin
    if (i_go)
    begin
      valid_q <= 1'b1;
      frame_q <= i_frame;
    end
    else if (valid_q && i_ready)
    begin
      valid_q <= 1'b0;
    end
  end
  // Released lines show the inverse
  assign o_valid = valid_q;
  assign o_frame = valid_q ? frame_q : ~frame_q;
endmodule
`default_nettype wire

// ===== sim/mar_resolver_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mar_resolver_tb;
  typedef struct packed {
    logic [4:0] c;
    logic [4:0] r;
    logic [5:0] g;
    logic [7:0] s;
    logic [3:0] q;
    logic [8:0] m;
    logic [2:0] p;
    logic t;
  } mar_row_t;
  localparam logic [47:0] HIT = 48'h01005e000001;
  localparam logic [47:0] MISS = 48'h01005e000002;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic go = 1'b0;
  logic [72:0] frm_in = '0;
  logic [72:0] frm;
  logic vld, rdy, pready, pslverr, rv, tcv, pc, er;
  logic [31:0] prdata, rd;
  logic [8:0] dm;
  logic [2:0] tc, path;
  logic [15:0] h;
  int err_count = 0;
  int checks = 0;
  mar_row_t rows [20];
  always #50 clk = ~clk;
  mar_ingress_model u_src (.i_clock(clk), .i_go(go), .i_frame(frm_in), .i_ready(rdy),
    .o_valid(vld), .o_frame(frm));
  mar_resolver DUT (.i_clock(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_req_valid(vld), .i_req_da(frm[72:25]), .i_req_vid(frm[24:13]),
    .i_req_src_port(frm[12:9]), .i_req_vlan_members(frm[8:0]), .o_req_ready(rdy),
    .o_rsp_valid(rv), .o_rsp_dest_mask(dm), .o_rsp_tc(tc), .o_rsp_tc_valid(tcv),
    .o_rsp_pause_check(pc), .o_rsp_path(path));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] crc(input logic [59:0] k);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 59; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ (c[15] ^ k[i] ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    for (int n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clk);
    chk(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic ent(input logic [31:0] d);
    apb(1'b1, 8'h10, {20'h0, h[9:0], 2'b00});
    apb(1'b1, 8'h14, HIT[31:0]);
    apb(1'b1, 8'h18, {16'h0, HIT[47:32]});
    apb(1'b1, 8'h1c, d);
    apb(1'b1, 8'h20, 32'h1);
  endtask
  task automatic run(input mar_row_t w);
    apb(1'b1, 8'h00, {27'h0, w.c});
    apb(1'b1, 8'h04, {27'h0, w.r});
    apb(1'b1, 8'h08, {26'h0, w.g});
    go <= 1'b1;
    frm_in <= {w.s == 8'hff ? HIT : w.s == 8'hfe ? MISS : {mar_pkg::RSV_PREFIX, w.s},
      w.c[1] ? 12'h003 : 12'h000, w.q, 9'h0ff};
    @(posedge clk);
    go <= 1'b0;
    for (int n = 0; n < 12 && rv !== 1'b1; n++) @(posedge clk);
    chk(rv, 1'b1);
    chk(dm, w.m);
    chk(path, w.p);
    chk(pc, w.s == 8'h01);
    chk(tcv, w.t);
    if (w.t)
      chk(tc, 3'h5);
  endtask
  initial
  begin
    rows = '{'{5'h00, 5'h00, 6'h00, 8'h00, 4'h0, 9'h0fe, 3'h1, 1'b0},
      '{5'h00, 5'h00, 6'h00, 8'h02, 4'h0, 9'h000, 3'h1, 1'b0},
      '{5'h00, 5'h00, 6'h00, 8'h01, 4'h0, 9'h000, 3'h1, 1'b0},
      '{5'h00, 5'h01, 6'h00, 8'h00, 4'h0, 9'h000, 3'h1, 1'b0},
      '{5'h00, 5'h02, 6'h00, 8'h0a, 4'h0, 9'h0fe, 3'h1, 1'b0},
      '{5'h00, 5'h04, 6'h00, 8'h10, 4'h0, 9'h000, 3'h1, 1'b0},
      '{5'h00, 5'h08, 6'h00, 8'h1f, 4'h0, 9'h000, 3'h1, 1'b0},
      '{5'h00, 5'h10, 6'h00, 8'h2f, 4'h3, 9'h000, 3'h1, 1'b0},
      '{5'h04, 5'h1f, 6'h00, 8'h00, 4'h0, 9'h100, 3'h1, 1'b0},
      '{5'h04, 5'h00, 6'h00, 8'h10, 4'h1, 9'h1fd, 3'h1, 1'b0},
      '{5'h04, 5'h00, 6'h00, 8'h15, 4'h1, 9'h0fd, 3'h1, 1'b0},
      '{5'h04, 5'h00, 6'h00, 8'h20, 4'h1, 9'h0fd, 3'h1, 1'b0},
      '{5'h04, 5'h00, 6'h10, 8'h20, 4'h1, 9'h100, 3'h1, 1'b0},
      '{5'h04, 5'h00, 6'h20, 8'h21, 4'h1, 9'h100, 3'h1, 1'b0},
      '{5'h01, 5'h00, 6'h00, 8'hff, 4'h0, 9'h0f6, 3'h3, 1'b1},
      '{5'h00, 5'h00, 6'h00, 8'hff, 4'h0, 9'h040, 3'h3, 1'b1},
      '{5'h03, 5'h00, 6'h00, 8'hff, 4'h0, 9'h0fe, 3'h0, 1'b0},
      '{5'h01, 5'h00, 6'h00, 8'hfe, 4'h2, 9'h0fb, 3'h0, 1'b0},
      '{5'h11, 5'h00, 6'h00, 8'hfe, 4'h0, 9'h0a4, 3'h4, 1'b0},
      '{5'h09, 5'h00, 6'h00, 8'hff, 4'h4, 9'h023, 3'h2, 1'b0}};
    h = crc({12'h000, HIT});
    repeat (12) @(posedge clk);
    chk({rdy, rv, pready, dm}, 12'h000);
    rstn <= 1'b1;
    apb(1'b0, 8'h24, 32'h0);
    chk(rd[1], 1'b1);
    apb(1'b0, 8'h30, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h0c, 32'h0a5);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0a5);
    apb(1'b1, 8'h40, HIT[31:0]);
    apb(1'b1, 8'h44, 32'h80330100);
    for (int n = 0; n < 5000 && rdy !== 1'b1; n++) @(posedge clk);
    chk(rdy, 1'b1);
    ent(32'h6af6);
    apb(1'b1, 8'h1c, 32'h0);
    apb(1'b1, 8'h20, 32'h2);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h6af6);
    $display("setup done");
    foreach (rows[i])
    begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    ent(32'h4af6);
    run('{5'h01, 5'h00, 6'h00, 8'hff, 4'h0, 9'h0f6, 3'h3, 1'b0});
    $display("dynamic entry done");
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire

// ===== sim/mar_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mar_sva
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic i_req_valid,
  input wire logic [47:0] i_req_da,
  input wire logic [3:0] i_req_src_port,
  input wire logic [8:0] i_req_vlan_members,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic [8:0] o_rsp_dest_mask,
  input wire logic o_rsp_tc_valid,
  input wire logic o_rsp_pause_check,
  input wire logic [2:0] o_rsp_path
);
  logic take;
  logic rsv;
  logic [3:0] src_q;
  logic [8:0] mem_q;
  assign take = i_req_valid && o_req_ready;
  assign rsv = i_req_da[47:8] == mar_pkg::RSV_PREFIX && i_req_da[7:0] <= mar_pkg::SFX_LAST;
  always_ff @(posedge i_clock)
  begin
    if (take)
    begin
      src_q <= i_req_src_port;
      mem_q <= i_req_vlan_members;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  sequence s_short;
    ##2 o_rsp_valid;
  endsequence
  sequence s_long;
    ##2 !o_rsp_valid ##3 o_rsp_valid;
  endsequence
  a_rsv_first: assert property (take && rsv |-> s_short ##0 o_rsp_path == 3'h1)
    else $error("reserved path missed");
  a_lookup_walk: assert property (take && !rsv |->
    (s_short ##0 o_rsp_path == 3'h2) or (s_long ##0 o_rsp_path != 3'h1))
    else $error("lookup timing wrong");
  a_pause_empty: assert property (o_rsp_valid && o_rsp_pause_check |->
    o_rsp_dest_mask == 9'h000 && o_rsp_path == 3'h1)
    else $error("pause frame forwarded");
  a_no_return: assert property (o_rsp_valid |-> !o_rsp_dest_mask[src_q])
    else $error("ingress port in mask");
  a_flood_members: assert property (o_rsp_valid && o_rsp_path == 3'h0 |->
    o_rsp_dest_mask == (mem_q & ~(9'h001 << src_q)))
    else $error("flood set wrong");
  a_tc_static: assert property (o_rsp_valid && o_rsp_tc_valid |-> o_rsp_path == 3'h3)
    else $error("class without table hit");
  a_apb_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb ready wrong");
  a_busy_hold: assert property (take |=> !o_req_ready)
    else $error("ready while busy");
endmodule
bind mar_resolver mar_sva u_sva (.i_clock, .i_rstn, .i_psel, .i_penable, .o_pready,
  .i_req_valid, .i_req_da, .i_req_src_port, .i_req_vlan_members, .o_req_ready,
  .o_rsp_valid, .o_rsp_dest_mask, .o_rsp_tc_valid, .o_rsp_pause_check, .o_rsp_path);
`default_nettype wire

// ===== src/mar_crc_hash.sv
`timescale 1ns/1ps
`default_nettype none

module mar_crc_hash
(
  input wire logic i_clock,
  input wire logic i_rstn,
  mar_hash_if.hasher hif
);

  function automatic logic [15:0] crc16(input logic [mar_pkg::KEY_W-1:0] key);
    logic [15:0] c;
    logic fb;
    c = mar_pkg::CRC_INIT;
    for (int i = mar_pkg::KEY_W - 1; i >= 0; i--)
    begin
      fb = c[15] ^ key[i];
      c = {c[14:0], 1'b0};
      if (fb)
      begin
        c = c ^ mar_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction

  logic [15:0] crc_d;
  logic done_q;
  logic [mar_pkg::BKT_W-1:0] bucket_q;

  assign crc_d = crc16(hif.key);

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      done_q <= 1'b0;
      bucket_q <= '0;
    end
    else
    begin
      done_q <= hif.start;
      if (hif.start)
      begin
        bucket_q <= crc_d[mar_pkg::BKT_W-1:0];
      end
    end
  end

  assign hif.done = done_q;
  assign hif.bucket = bucket_q;

endmodule

`default_nettype wire

// ===== src/mar_hash_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mar_hash_if;
  logic start;
  logic [mar_pkg::KEY_W-1:0] key;
  logic done;
  logic [mar_pkg::BKT_W-1:0] bucket;

  modport requester (output start, output key, input done, input bucket);
  modport hasher (input start, input key, output done, output bucket);
endinterface

`default_nettype wire

// ===== src/mar_pkg.sv
package mar_pkg;

  localparam int NPORT = 9;
  localparam int MGMT_PORT = 8;
  localparam int NMPORT = 6;
  localparam int BKT_W = 10;
  localparam int IDX_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int KEY_W = 60;

  localparam logic [8:0] ALL_MASK = 9'h1ff;
  localparam logic [8:0] MGMT_MASK = 9'h100;

  // Entry layout
  localparam int ENTRY_W = 75;
  localparam int E_MASK_LSB = 0;
  localparam int E_TC_LSB = 9;
  localparam int E_AGE = 12;
  localparam int E_STATIC = 13;
  localparam int E_VALID = 14;
  localparam int E_MAC_LSB = 15;
  localparam int E_VID_LSB = 63;

  // Reserved group range
  localparam logic [39:0] RSV_PREFIX = 40'h0180c20000;
  localparam logic [7:0] SFX_BRIDGE = 8'h00;
  localparam logic [7:0] SFX_PAUSE = 8'h01;
  localparam logic [7:0] SFX_MGMT_LAST = 8'h0f;
  localparam logic [7:0] SFX_ALL_LANS = 8'h10;
  localparam logic [7:0] SFX_LOW_LAST = 8'h1f;
  localparam logic [7:0] SFX_GMRP = 8'h20;
  localparam logic [7:0] SFX_GVRP = 8'h21;
  localparam logic [7:0] SFX_LAST = 8'h2f;

  // Reserved control bit groups
  localparam int RSV_B_BRIDGE = 0;
  localparam int RSV_B_MGMT = 1;
  localparam int RSV_B_ALLLAN = 2;
  localparam int RSV_B_LOW = 3;
  localparam int RSV_B_HIGH = 4;
  localparam int GMRP_BIT = 4;
  localparam int GVRP_BIT = 5;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RSV_CTRL = 8'h04;
  localparam logic [7:0] REG_GARP_CTRL = 8'h08;
  localparam logic [7:0] REG_MISS_MAP = 8'h0c;
  localparam logic [7:0] REG_TBL_IDX = 8'h10;
  localparam logic [7:0] REG_TBL_MAC_LO = 8'h14;
  localparam logic [7:0] REG_TBL_MAC_HI = 8'h18;
  localparam logic [7:0] REG_TBL_DATA = 8'h1c;
  localparam logic [7:0] REG_TBL_CMD = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_MP_BASE = 8'h40;
  localparam logic [7:0] REG_MP_END = 8'h6f;

  // CTRL fields
  localparam int CTRL_GROUP_SEL = 0;
  localparam int CTRL_VLAN_KEY = 1;
  localparam int CTRL_MANAGED = 2;
  localparam int CTRL_MP_EN = 3;
  localparam int CTRL_MISS_EN = 4;
  localparam int CMD_WR = 0;
  localparam int CMD_RD = 1;
  localparam int MP_VALID_BIT = 31;

  // Hash
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  typedef enum logic [2:0] {
    PATH_FLOOD,
    PATH_RESERVED,
    PATH_MULTIPORT,
    PATH_TABLE,
    PATH_MISS_MAP
  } mar_path_t;

endpackage

// ===== src/mar_resolver.sv
// Functional notes
// - Group select on: matched entry's port mask is the destination; no match floods.
// - First test DA against 01-80-C2-00-00-00..2F; reserved action replaces lookup.
// - Multiport enabled and not reserved: matching multiport entry gives the vector.
// - Otherwise low ten hash bits point at the bucket to fetch.
// - Valid entry with equal key supplies its port map.
// - Miss with miss-forward set uses the lookup-miss port map.
// - Anything still unresolved floods to all appropriate ports.
// - Key is DA plus VID when VLAN keying set; field is port ID or mask.
// - Entry holds VID, valid, static, class, 48-bit address, nine-bit port mask.
// - Entry traffic class used only for static entries.
// - Age bit of static entries is ignored; they never age.
// - Five reserved control bits override unmanaged drop or flood defaults.
// - Managed: 00 and 02-0F to management port only; 10 to all ports.
// - Unmanaged floods 00,10-2F, drops 02-0F; managed 11-1F,22-2F exclude management.
// - Suffix 01 goes to the receive MAC pause check in both modes.
// - Managed 20/21 exclude management port, or management only when bit 4/5 set.
// - Reserved floods still honour VLAN membership exclusions.
// - Static entries are never learned over or aged by hardware.
// - Software may write static unicast or multicast entries at any location.
// - Index is CRC-CCITT of address and optional VID.
// - Bucket of four: bins 0,1 read one cycle, bins 2,3 the next.
// - Hardware never learns multicast entries; only software writes the table.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module mar_resolver
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_req_valid,
  input wire logic [47:0] i_req_da,
  input wire logic [11:0] i_req_vid,
  input wire logic [3:0] i_req_src_port,
  input wire logic [8:0] i_req_vlan_members,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [8:0] o_rsp_dest_mask,
  output logic [2:0] o_rsp_tc,
  output logic o_rsp_tc_valid,
  output logic o_rsp_pause_check,
  output logic [2:0] o_rsp_path
);

  typedef enum logic [2:0] {S_INIT, S_IDLE, S_CHECK, S_HASH, S_BIN01, S_BIN23} mar_state_t;

  mar_state_t state_q, state_d;
  mar_hash_if hif ();

  mar_crc_hash u_hash
  (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .hif(hif)
  );

  // Software-visible registers
  logic [4:0] ctrl_q;
  logic [4:0] rsv_ctrl_q;
  logic [5:0] garp_ctrl_q;
  logic [8:0] miss_map_q;
  logic [mar_pkg::IDX_W-1:0] tbl_idx_q;
  logic [mar_pkg::ENTRY_W-1:0] stage_q;
  logic [47:0] mp_addr_q [mar_pkg::NMPORT];
  logic [8:0] mp_vec_q [mar_pkg::NMPORT];
  logic [mar_pkg::NMPORT-1:0] mp_valid_q;
  logic [mar_pkg::ENTRY_W-1:0] mem_q [mar_pkg::MEM_DEPTH];
  logic [mar_pkg::IDX_W-1:0] init_cnt_q;

  logic apb_go, apb_wr;
  logic [31:0] rd_data;
  logic rd_err;
  logic [2:0] mp_sel;
  logic [7:0] mp_off;

  assign apb_go = i_psel && i_penable && !o_pready;
  // Writes land at the edge that completes the transfer
  assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;
  assign mp_off = i_paddr - mar_pkg::REG_MP_BASE;
  assign mp_sel = mp_off[5:3];

  // APB handshake: answer one cycle into the access phase
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= apb_go;
      o_pslverr <= apb_go && rd_err;
      o_prdata <= (apb_go && !i_pwrite && !rd_err) ? rd_data : '0;
    end
  end

  always_comb
  begin
    rd_data = '0;
    rd_err = 1'b0;
    case (i_paddr)
      mar_pkg::REG_CTRL: rd_data[4:0] = ctrl_q;
      mar_pkg::REG_RSV_CTRL: rd_data[4:0] = rsv_ctrl_q;
      mar_pkg::REG_GARP_CTRL: rd_data[5:0] = garp_ctrl_q;
      mar_pkg::REG_MISS_MAP: rd_data[8:0] = miss_map_q;
      mar_pkg::REG_TBL_IDX: rd_data[11:0] = tbl_idx_q;
      mar_pkg::REG_TBL_MAC_LO: rd_data = stage_q[mar_pkg::E_MAC_LSB +: 32];
      mar_pkg::REG_TBL_MAC_HI: rd_data[27:0] = {stage_q[mar_pkg::E_VID_LSB +: 12],
                                                  stage_q[mar_pkg::E_MAC_LSB+32 +: 16]};
      mar_pkg::REG_TBL_DATA: rd_data[14:0] = {stage_q[mar_pkg::E_VALID], stage_q[mar_pkg::E_STATIC],
                                               stage_q[mar_pkg::E_AGE], stage_q[11:0]};
      mar_pkg::REG_TBL_CMD: rd_data = '0;
      mar_pkg::REG_STATUS: rd_data[4:0] = {o_rsp_path, state_q == mar_state_t'(S_INIT),
                                           state_q != mar_state_t'(S_IDLE)};
      default:
      begin
        if (i_paddr >= mar_pkg::REG_MP_BASE && i_paddr <= mar_pkg::REG_MP_END
            && i_paddr[1:0] == 2'b00)
        begin
          if (mp_off[2])
          begin
            rd_data = {mp_valid_q[mp_sel], 6'h00, mp_vec_q[mp_sel], mp_addr_q[mp_sel][47:32]};
          end
          else
          begin
            rd_data = mp_addr_q[mp_sel][31:0];
          end
        end
        else
        begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      ctrl_q <= '0;
      rsv_ctrl_q <= '0;
      garp_ctrl_q <= '0;
      miss_map_q <= '0;
      tbl_idx_q <= '0;
    end
    else if (apb_wr)
    begin
      case (i_paddr)
        mar_pkg::REG_CTRL: ctrl_q <= i_pwdata[4:0];
        mar_pkg::REG_RSV_CTRL: rsv_ctrl_q <= i_pwdata[4:0];
        mar_pkg::REG_GARP_CTRL: garp_ctrl_q <= i_pwdata[5:0];
        mar_pkg::REG_MISS_MAP: miss_map_q <= i_pwdata[8:0];
        mar_pkg::REG_TBL_IDX: tbl_idx_q <= i_pwdata[11:0];
        default: ;
      endcase
    end
  end

  // Multiport registers
  for (genvar n = 0; n < mar_pkg::NMPORT; n++)
  begin : g_mp_regs
    always_ff @(posedge i_clock)
    begin
      if (!i_rstn)
      begin
        mp_addr_q[n] <= '0;
        mp_vec_q[n] <= '0;
        mp_valid_q[n] <= 1'b0;
      end
      else if (apb_wr && i_paddr >= mar_pkg::REG_MP_BASE && i_paddr <= mar_pkg::REG_MP_END
               && i_paddr[1:0] == 2'b00 && mp_sel == 3'(n))
      begin
        if (mp_off[2])
        begin
          mp_addr_q[n][47:32] <= i_pwdata[15:0];
          mp_vec_q[n] <= i_pwdata[24:16];
          mp_valid_q[n] <= i_pwdata[mar_pkg::MP_VALID_BIT];
        end
        else
        begin
          mp_addr_q[n][31:0] <= i_pwdata;
        end
      end
    end
  end

  // Table staging word, filled by software or by a table read
  logic cmd_wr, cmd_rd;
  assign cmd_wr = apb_wr && i_paddr == mar_pkg::REG_TBL_CMD && i_pwdata[mar_pkg::CMD_WR]
                  && state_q != mar_state_t'(S_INIT);
  assign cmd_rd = apb_wr && i_paddr == mar_pkg::REG_TBL_CMD && i_pwdata[mar_pkg::CMD_RD];

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      stage_q <= '0;
    end
    else if (cmd_rd)
    begin
      stage_q <= mem_q[tbl_idx_q];
    end
    else if (apb_wr)
    begin
      case (i_paddr)
        mar_pkg::REG_TBL_MAC_LO: stage_q[mar_pkg::E_MAC_LSB +: 32] <= i_pwdata;
        mar_pkg::REG_TBL_MAC_HI:
        begin
          stage_q[mar_pkg::E_MAC_LSB+32 +: 16] <= i_pwdata[15:0];
          stage_q[mar_pkg::E_VID_LSB +: 12] <= i_pwdata[27:16];
        end
        mar_pkg::REG_TBL_DATA:
        begin
          stage_q[11:0] <= i_pwdata[11:0];
          stage_q[mar_pkg::E_AGE] <= i_pwdata[12];
          stage_q[mar_pkg::E_STATIC] <= i_pwdata[13];
          stage_q[mar_pkg::E_VALID] <= i_pwdata[14];
        end
        default: ;
      endcase
    end
  end

  // Table memory: cleared after reset, then written only by software
  always_ff @(posedge i_clock)
  begin
    if (state_q == mar_state_t'(S_INIT))
    begin
      mem_q[init_cnt_q] <= '0;
    end
    else if (cmd_wr)
    begin
      mem_q[tbl_idx_q] <= stage_q;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      init_cnt_q <= '0;
    end
    else if (state_q == mar_state_t'(S_INIT))
    begin
      init_cnt_q <= init_cnt_q + 12'h001;
    end
  end

  // Lookup request capture
  logic [47:0] da_q;
  logic [11:0] vid_q;
  logic [8:0] excl_q;
  logic [8:0] flood_q;
  logic [mar_pkg::BKT_W-1:0] bkt_q;
  logic take;

  assign take = i_req_valid && o_req_ready;

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      da_q <= '0;
      vid_q <= '0;
      excl_q <= '0;
      flood_q <= '0;
    end
    else if (take)
    begin
      da_q <= i_req_da;
      vid_q <= ctrl_q[mar_pkg::CTRL_VLAN_KEY] ? i_req_vid : 12'h000;
      excl_q <= 9'(i_req_src_port < 4'(mar_pkg::NPORT) ? 9'h001 << i_req_src_port : 9'h000);
      flood_q <= mar_pkg::ALL_MASK & i_req_vlan_members;
    end
  end

  assign hif.key = {vid_q, da_q};

  // Reserved range action
  logic rsv_hit;
  logic [7:0] sfx;
  logic [8:0] rsv_dest;
  logic rsv_pause;
  logic [8:0] all_ex;

  assign sfx = da_q[7:0];
  assign rsv_hit = da_q[47:8] == mar_pkg::RSV_PREFIX && sfx <= mar_pkg::SFX_LAST;
  assign all_ex = flood_q & ~excl_q;

  always_comb
  begin
    rsv_dest = '0;
    rsv_pause = 1'b0;
    if (sfx == mar_pkg::SFX_PAUSE)
    begin
      rsv_pause = 1'b1;
    end
    else if (ctrl_q[mar_pkg::CTRL_MANAGED])
    begin
      if (sfx <= mar_pkg::SFX_MGMT_LAST)
        rsv_dest = mar_pkg::MGMT_MASK & ~excl_q;
      else if (sfx == mar_pkg::SFX_ALL_LANS)
        rsv_dest = (all_ex | mar_pkg::MGMT_MASK) & ~excl_q;
      else if (sfx == mar_pkg::SFX_GMRP && garp_ctrl_q[mar_pkg::GMRP_BIT])
        rsv_dest = mar_pkg::MGMT_MASK & ~excl_q;
      else if (sfx == mar_pkg::SFX_GVRP && garp_ctrl_q[mar_pkg::GVRP_BIT])
        rsv_dest = mar_pkg::MGMT_MASK & ~excl_q;
      else
        rsv_dest = all_ex & ~mar_pkg::MGMT_MASK;
    end
    else
    begin
      if (sfx == mar_pkg::SFX_BRIDGE)
        rsv_dest = rsv_ctrl_q[mar_pkg::RSV_B_BRIDGE] ? 9'h000 : all_ex;
      else if (sfx <= mar_pkg::SFX_MGMT_LAST)
        rsv_dest = rsv_ctrl_q[mar_pkg::RSV_B_MGMT] ? all_ex : 9'h000;
      else if (sfx == mar_pkg::SFX_ALL_LANS)
        rsv_dest = rsv_ctrl_q[mar_pkg::RSV_B_ALLLAN] ? 9'h000 : all_ex;
      else if (sfx <= mar_pkg::SFX_LOW_LAST)
        rsv_dest = rsv_ctrl_q[mar_pkg::RSV_B_LOW] ? 9'h000 : all_ex;
      else
        rsv_dest = rsv_ctrl_q[mar_pkg::RSV_B_HIGH] ? 9'h000 : all_ex;
    end
  end

  // Multiport compare, lowest entry wins
  logic [mar_pkg::NMPORT-1:0] mp_match;
  logic mp_hit;
  logic [8:0] mp_dest;

  for (genvar n = 0; n < mar_pkg::NMPORT; n++)
  begin : g_mp_cmp
    assign mp_match[n] = mp_valid_q[n] && mp_addr_q[n] == da_q;
  end

  assign mp_hit = ctrl_q[mar_pkg::CTRL_MP_EN] && !rsv_hit && |mp_match;
  assign hif.start = state_q == mar_state_t'(S_CHECK) && !rsv_hit && !mp_hit;

  always_comb
  begin
    mp_dest = '0;
    for (int n = mar_pkg::NMPORT - 1; n >= 0; n--)
    begin
      if (mp_match[n])
        mp_dest = mp_vec_q[n] & ~excl_q;
    end
  end

  // Bucket bins: two per cycle
  logic [mar_pkg::ENTRY_W-1:0] bin_a, bin_b, hit_entry_q;
  logic hit_a, hit_b, hit_q;
  logic [1:0] bin_base;

  assign bin_base = state_q == mar_state_t'(S_BIN23) ? 2'd2 : 2'd0;
  assign bin_a = mem_q[{bkt_q, bin_base}];
  assign bin_b = mem_q[{bkt_q, bin_base | 2'd1}];

  function automatic logic entry_hit(input logic [mar_pkg::ENTRY_W-1:0] e,
                                     input logic [47:0] da, input logic [11:0] vid);
    return e[mar_pkg::E_VALID] && e[mar_pkg::E_MAC_LSB +: 48] == da
           && e[mar_pkg::E_VID_LSB +: 12] == vid;
  endfunction

  assign hit_a = entry_hit(bin_a, da_q, vid_q);
  assign hit_b = entry_hit(bin_b, da_q, vid_q);

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      hit_q <= 1'b0;
      hit_entry_q <= '0;
      bkt_q <= '0;
    end
    else
    begin
      if (hif.done)
        bkt_q <= hif.bucket;
      if (state_q == mar_state_t'(S_BIN01))
      begin
        hit_q <= hit_a || hit_b;
        hit_entry_q <= hit_a ? bin_a : bin_b;
      end
    end
  end

  // Final decision after the second pair
  logic tbl_hit;
  logic [mar_pkg::ENTRY_W-1:0] tbl_entry;
  logic [8:0] tbl_dest;
  logic [3:0] tbl_pid;

  assign tbl_hit = hit_q || hit_a || hit_b;
  assign tbl_entry = hit_q ? hit_entry_q : (hit_a ? bin_a : bin_b);
  assign tbl_pid = tbl_entry[3:0];

  always_comb
  begin
    if (ctrl_q[mar_pkg::CTRL_GROUP_SEL])
      tbl_dest = tbl_entry[8:0] & ~excl_q;
    else
      tbl_dest = 9'(tbl_pid < 4'(mar_pkg::NPORT) ? 9'h001 << tbl_pid : 9'h000) & ~excl_q;
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_INIT: state_d = init_cnt_q == 12'hfff ? S_IDLE : S_INIT;
      S_IDLE: state_d = take ? S_CHECK : S_IDLE;
      S_CHECK: state_d = (rsv_hit || mp_hit) ? S_IDLE : S_HASH;
      S_HASH: state_d = hif.done ? S_BIN01 : S_HASH;
      S_BIN01: state_d = S_BIN23;
      S_BIN23: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      state_q <= S_INIT;
      o_req_ready <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      o_req_ready <= state_d == S_IDLE;
    end
  end

  // Response
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_dest_mask <= '0;
      o_rsp_tc <= '0;
      o_rsp_tc_valid <= 1'b0;
      o_rsp_pause_check <= 1'b0;
      o_rsp_path <= mar_pkg::PATH_FLOOD;
    end
    else
    begin
      o_rsp_valid <= 1'b0;
      if (state_q == S_CHECK && (rsv_hit || mp_hit))
      begin
        o_rsp_valid <= 1'b1;
        o_rsp_tc <= '0;
        o_rsp_tc_valid <= 1'b0;
        o_rsp_pause_check <= rsv_hit && rsv_pause;
        o_rsp_dest_mask <= rsv_hit ? rsv_dest : mp_dest;
        o_rsp_path <= rsv_hit ? mar_pkg::PATH_RESERVED : mar_pkg::PATH_MULTIPORT;
      end
      else if (state_q == S_BIN23)
      begin
        o_rsp_valid <= 1'b1;
        o_rsp_pause_check <= 1'b0;
        o_rsp_tc <= tbl_entry[mar_pkg::E_TC_LSB +: 3];
        o_rsp_tc_valid <= tbl_hit && tbl_entry[mar_pkg::E_STATIC];
        if (tbl_hit)
        begin
          o_rsp_dest_mask <= tbl_dest;
          o_rsp_path <= mar_pkg::PATH_TABLE;
        end
        else if (ctrl_q[mar_pkg::CTRL_MISS_EN])
        begin
          o_rsp_dest_mask <= miss_map_q & ~excl_q;
          o_rsp_path <= mar_pkg::PATH_MISS_MAP;
        end
        else
        begin
          o_rsp_dest_mask <= all_ex;
          o_rsp_path <= mar_pkg::PATH_FLOOD;
        end
      end
    end
  end

endmodule

`default_nettype wire
